//--- cache_tlb_pkg.sv
// Shared constants and carrier types for the cache and TLB test-access block
package cache_tlb_pkg;

  // Wishbone request carrier; adr holds byte address bits 16:2
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [16:2] adr;
    logic [31:0] dat;
  } wb_req_t;

  // Coprocessor transfer selector carried in adr[15:2]
  typedef struct packed {
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } cp_op_t;

  // Byte offsets of the interrupt registers (adr[16] set)
  localparam logic [16:0] IRQ_STATUS_OFS = 17'h10000;
  localparam logic [16:0] IRQ_ENABLE_OFS = 17'h10004;
  localparam logic [16:0] IRQ_CLEAR_OFS = 17'h10008;
  localparam int unsigned IRQ_SPACE_BIT = 16;

  // Event bits
  localparam int unsigned EV_TLB_MISS = 0;
  localparam int unsigned EV_TLB_INV = 1;
  localparam int unsigned EV_CACHE_MISS = 2;
  localparam int unsigned EV_W = 3;

  // Opcode fields
  localparam logic [2:0] OP1_SYS = 3'h0;
  localparam logic [2:0] OP1_CACHE = 3'h2;
  localparam logic [2:0] OP1_CDATA = 3'h3;
  localparam logic [2:0] OP1_MMU = 3'h4;
  localparam logic [2:0] OP1_TSTATE = 3'h7;
  localparam logic [3:0] CRN_BASE = 4'h2;
  localparam logic [3:0] CRN_DOMAIN = 4'h3;
  localparam logic [3:0] CRN_FSTAT = 4'h5;
  localparam logic [3:0] CRN_FADDR = 4'h6;
  localparam logic [3:0] CRN_TLBINV = 4'h8;
  localparam logic [3:0] CRN_VICTIM = 4'h9;
  localparam logic [3:0] CRN_TLBLOCK = 4'hA;
  localparam logic [3:0] CRN_TEST = 4'hF;
  localparam logic [3:0] CRM_CAM = 4'h7;
  localparam logic [3:0] CRM_RAM = 4'hB;
  localparam logic [3:0] CRM_DATA = 4'h3;
  localparam logic [3:0] CRM_MATCH = 4'hD;
  localparam logic [3:0] CRM_TSTATE = 4'hF;
  localparam logic [2:0] OP2_CRD = 3'h2;
  localparam logic [2:0] OP2_CWR = 3'h6;
  localparam logic [2:0] OP2_CMATCH = 3'h5;
  localparam logic [2:0] OP2_TRD = 3'h4;
  localparam logic [2:0] OP2_TWR = 3'h0;
  localparam logic [2:0] OP2_R2RD = 3'h5;
  localparam logic [2:0] OP2_R2WR = 3'h1;
  localparam logic [2:0] OP2_MREAD = 3'h6;
  localparam logic [2:0] OP2_TSTATE = 3'h7;

  // Operand field positions
  localparam int unsigned IDX_LSB = 26;
  localparam int unsigned TVIC_LSB = 20;
  localparam int unsigned SEG_LSB = 5;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned CTAG_LSB = 7;
  localparam int unsigned TTAG_LSB = 10;
  localparam int unsigned SIZE_LSB = 6;
  localparam int unsigned VALID_BIT = 5;
  localparam int unsigned PRES_BIT = 4;
  localparam int unsigned MISS_BIT = 22;

  // Region size and access permission encodings
  localparam logic [3:0] SIZE_1MB = 4'hF;
  localparam logic [3:0] SIZE_64KB = 4'h7;
  localparam logic [3:0] SIZE_16KB = 4'h3;
  localparam logic [3:0] SIZE_4KB = 4'h1;
  localparam logic [3:0] APSEL_11 = 4'h8;
  localparam logic [3:0] APSEL_10 = 4'h4;
  localparam logic [3:0] APSEL_01 = 4'h2;
  localparam logic [5:0] IDX_MAX = 6'h3F;
  localparam logic [31:0] RST_WORD = 32'h0;

endpackage : cache_tlb_pkg

//--- cache_tlb_test_access.sv
// Cache and TLB test-access logic behind a classic Wishbone slave
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps

// How it works
// - Cache match operand: tag, segment, word fields
// - Base-mode victim advances on CAM and RAM
// - Victim-only mode advances on CAM access only
// - Base write loads victim and base from 31:26
// - Victim write takes index 31:26, segment 6:5
// - CAM read captures current segment victim pointer
// - Register 8 invalidates all unpreserved TLB entries or matching entries
// - Register 10 holds TLB victim, base, preserve
// - TLB match miss only reports, never walks
// - TLB test results latch into MMU data
// - TLB CAM word: tag, size, valid, preserve
// - Four-bit region size decodes 1MB to 1KB
// - One-hot permission select maps to two bits
// - TLB test opcodes decoded on register 15
// - Base, domain, fault status, address registers
// - Cache CAM read returns zero bits 6:5
// - RAM2 uses delayed victim of prior access
// - Test state bit gates tests, reset clear
module cache_tlb_test_access (
  input wire logic mclk,
  input wire logic arst_n,
  input cache_tlb_pkg::wb_req_t wb_req,
  output logic wb_ack,
  output logic [31:0] wb_dat_o,
  output logic irq
);

  cache_tlb_pkg::cp_op_t op;
  logic acc, cop, wr, rd;
  logic [31:0] wd;
  logic [1:0] seg;
  logic [2:0] word;
  logic [5:0] cidx;
  logic ack_q;
  logic [31:0] dat_q, rdata_d;
  logic test_en_q;

  function automatic logic is_op(cache_tlb_pkg::cp_op_t o, logic [2:0] a, logic [3:0] n,
                                 logic [3:0] m, logic [2:0] b);
    is_op = (o.op1 == a) && (o.crn == n) && (o.crm == m) && (o.op2 == b);
  endfunction : is_op

  // Compare mask over tag bits 19:10; a set bit takes part in the match
  function automatic logic [9:0] size_mask(logic [3:0] s);
    case (s)
      cache_tlb_pkg::SIZE_1MB: size_mask = 10'h000;
      cache_tlb_pkg::SIZE_64KB: size_mask = 10'h3C0;
      cache_tlb_pkg::SIZE_16KB: size_mask = 10'h3F0;
      cache_tlb_pkg::SIZE_4KB: size_mask = 10'h3FC;
      default: size_mask = 10'h3FF;
    endcase
  endfunction : size_mask

  function automatic logic [1:0] perm_decode(logic [3:0] access_perm_select);
    case (access_perm_select)
      cache_tlb_pkg::APSEL_11: perm_decode = 2'h3;
      cache_tlb_pkg::APSEL_10: perm_decode = 2'h2;
      cache_tlb_pkg::APSEL_01: perm_decode = 2'h1;
      default: perm_decode = 2'h0;
    endcase
  endfunction : perm_decode

  // A request executes in the cycle it is first seen; ack follows one edge later
  assign acc = wb_req.cyc & wb_req.stb & ~ack_q;
  assign op = cache_tlb_pkg::cp_op_t'(wb_req.adr[15:2]);
  assign cop = acc & ~wb_req.adr[cache_tlb_pkg::IRQ_SPACE_BIT];
  assign wr = cop & wb_req.we & (wb_req.sel == 4'hF);
  assign rd = cop & ~wb_req.we;
  assign wd = wb_req.dat;
  assign seg = wd[cache_tlb_pkg::SEG_LSB +: 2];
  assign word = wd[cache_tlb_pkg::WORD_LSB +: 3];
  assign cidx = wd[cache_tlb_pkg::IDX_LSB +: 6];

  // Test operations are dropped while the test state bit is clear
  logic c_camrd, c_camwr, c_ramrd, c_ramwr, c_match, c_dwr;
  logic t_camrd, t_camwr, t_r1rd, t_r1wr, t_r2rd, t_r2wr, t_match;
  logic tst_wr, vlb_wr, vic_wr, inv_all, inv_one, tlk_wr, twr;
  assign twr = wr & test_en_q;
  assign c_camrd = twr & is_op(op, cache_tlb_pkg::OP1_CACHE, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_CAM, cache_tlb_pkg::OP2_CRD);
  assign c_camwr = twr & is_op(op, cache_tlb_pkg::OP1_CACHE, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_CAM, cache_tlb_pkg::OP2_CWR);
  assign c_match = twr & is_op(op, cache_tlb_pkg::OP1_CACHE, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_CAM, cache_tlb_pkg::OP2_CMATCH);
  assign c_ramrd = twr & is_op(op, cache_tlb_pkg::OP1_CACHE, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_RAM, cache_tlb_pkg::OP2_CRD);
  assign c_ramwr = twr & is_op(op, cache_tlb_pkg::OP1_CACHE, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_RAM, cache_tlb_pkg::OP2_CWR);
  assign c_dwr = twr & is_op(op, cache_tlb_pkg::OP1_CDATA, cache_tlb_pkg::CRN_TEST,
                             cache_tlb_pkg::CRM_DATA, 3'h0);
  assign t_camrd = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_CAM, cache_tlb_pkg::OP2_TRD);
  assign t_camwr = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_CAM, cache_tlb_pkg::OP2_TWR);
  assign t_r1rd = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                              cache_tlb_pkg::CRM_RAM, cache_tlb_pkg::OP2_TRD);
  assign t_r1wr = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                              cache_tlb_pkg::CRM_RAM, cache_tlb_pkg::OP2_TWR);
  assign t_r2rd = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                              cache_tlb_pkg::CRM_DATA, cache_tlb_pkg::OP2_R2RD);
  assign t_r2wr = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                              cache_tlb_pkg::CRM_DATA, cache_tlb_pkg::OP2_R2WR);
  assign t_match = twr & is_op(op, cache_tlb_pkg::OP1_MMU, cache_tlb_pkg::CRN_TEST,
                               cache_tlb_pkg::CRM_MATCH, cache_tlb_pkg::OP2_TRD);
  assign tst_wr = wr & is_op(op, cache_tlb_pkg::OP1_TSTATE, cache_tlb_pkg::CRN_TEST,
                             cache_tlb_pkg::CRM_TSTATE, cache_tlb_pkg::OP2_TSTATE);
  assign vlb_wr = wr & (op.op1 == cache_tlb_pkg::OP1_SYS) & (op.crn == cache_tlb_pkg::CRN_VICTIM)
                  & (op.crm == 4'h0) & (op.op2[2:1] == 2'h0);
  assign vic_wr = wr & (op.op1 == cache_tlb_pkg::OP1_SYS) & (op.crn == cache_tlb_pkg::CRN_VICTIM)
                  & (op.crm == 4'h1) & (op.op2[2:1] == 2'h0);
  assign inv_all = wr & (op.op1 == cache_tlb_pkg::OP1_SYS) & (op.crn == cache_tlb_pkg::CRN_TLBINV)
                   & (op.crm >= 4'h5) & (op.crm <= 4'h7) & (op.op2 == 3'h0);
  assign inv_one = wr & (op.op1 == cache_tlb_pkg::OP1_SYS) & (op.crn == cache_tlb_pkg::CRN_TLBINV)
                   & (op.crm >= 4'h5) & (op.crm <= 4'h7) & (op.op2 == 3'h1);
  assign tlk_wr = wr & is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_TLBLOCK, 4'h0, 3'h0);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      test_en_q <= 1'b0;
    end else if (tst_wr) begin
      test_en_q <= wd[0];
    end
  end

  // Cache victim pointers, one per segment, wrapping back to the lockdown base
  logic [5:0] cvp_q [4];
  logic [5:0] cbase_q, cvp_sel, cvp_inc, cvcap_q;
  logic auto_all_q;
  assign cvp_sel = cvp_q[seg];
  assign cvp_inc = (cvp_sel == cache_tlb_pkg::IDX_MAX) ? cbase_q : cvp_sel + 6'h01;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int s = 0; s < 4; s++) begin
        cvp_q[s] <= 6'h00;
      end
      cbase_q <= 6'h00;
      auto_all_q <= 1'b0;
    end else if (vlb_wr) begin
      for (int s = 0; s < 4; s++) begin
        cvp_q[s] <= cidx;
      end
      cbase_q <= cidx;
      auto_all_q <= 1'b1;
    end else if (vic_wr) begin
      cvp_q[seg] <= cidx;
      auto_all_q <= 1'b0;
    end else if (c_camrd | c_camwr | ((c_ramrd | c_ramwr) & auto_all_q)) begin
      cvp_q[seg] <= cvp_inc;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cvcap_q <= 6'h00;
    end else if (c_camrd) begin
      cvcap_q <= cvp_sel;
    end
  end

  // Cache arrays are data only and carry no reset, which keeps them cheap
  logic [31:0] ccam_q [4][64];
  logic [31:0] cram_q [4][64][8];
  logic [31:0] cache_test_data_reg_q;
  logic [63:0] chit;
  logic [5:0] chit_idx;

  always_ff @(posedge mclk) begin
    if (c_camwr) begin
      ccam_q[seg][cvp_sel] <= {wd[31:cache_tlb_pkg::CTAG_LSB], 2'b00, wd[4:0]};
    end
    if (c_ramwr) begin
      cram_q[seg][cvp_sel][word] <= cache_test_data_reg_q;
    end
  end

  for (genvar i = 0; i < 64; i++) begin : g_chit
    assign chit[i] = ccam_q[seg][i][31:cache_tlb_pkg::CTAG_LSB] ==
                     wd[31:cache_tlb_pkg::CTAG_LSB];
  end

  always_comb begin
    chit_idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (chit[i]) begin
        chit_idx = 6'(i);
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cache_test_data_reg_q <= cache_tlb_pkg::RST_WORD;
    end else if (c_dwr) begin
      cache_test_data_reg_q <= wd;
    end else if (c_camrd) begin
      cache_test_data_reg_q <= {ccam_q[seg][cvp_sel][31:7], 2'b00,
                                ccam_q[seg][cvp_sel][4:0]};
    end else if (c_ramrd) begin
      cache_test_data_reg_q <= cram_q[seg][cvp_sel][word];
    end else if (c_match & |chit) begin
      cache_test_data_reg_q <= cram_q[seg][chit_idx][word];
    end
  end

  // TLB lockdown: victim, base and preserve
  logic [5:0] tvp_q, tbase_q, tvp_inc, r2idx_q;
  logic tpres_q;
  assign tvp_inc = (tvp_q == cache_tlb_pkg::IDX_MAX) ? tbase_q : tvp_q + 6'h01;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tvp_q <= 6'h00;
      tbase_q <= 6'h00;
      tpres_q <= 1'b0;
    end else if (tlk_wr) begin
      tbase_q <= wd[cache_tlb_pkg::IDX_LSB +: 6];
      tvp_q <= wd[cache_tlb_pkg::TVIC_LSB +: 6];
      tpres_q <= wd[0];
    end else if (t_r2rd | t_r2wr) begin
      tvp_q <= tvp_inc;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r2idx_q <= 6'h00;
    end else if (t_camrd | t_camwr | t_r1rd | t_r1wr) begin
      r2idx_q <= tvp_q;
    end
  end

  logic [31:0] tcam_q [64];
  logic [31:0] tr1_q [64];
  logic [31:0] tr2_q [64];
  logic [63:0] thit;
  logic [5:0] thit_idx;
  logic [31:0] modified_virtual_address;
  assign modified_virtual_address = wd;

  // Preserved entries survive a whole-TLB invalidate
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 64; i++) begin
        tcam_q[i] <= cache_tlb_pkg::RST_WORD;
      end
    end else if (t_camwr) begin
      tcam_q[tvp_q] <= {wd[31:cache_tlb_pkg::PRES_BIT], 4'h0};
    end else begin
      for (int i = 0; i < 64; i++) begin
        if ((inv_all & ~tcam_q[i][cache_tlb_pkg::PRES_BIT]) | (inv_one & thit[i])) begin
          tcam_q[i][cache_tlb_pkg::VALID_BIT] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (t_r1wr) begin
      tr1_q[tvp_q] <= {wd[31:4], 2'b00, perm_decode(wd[3:0])};
    end
    if (t_r2wr) begin
      tr2_q[r2idx_q] <= {wd[31:cache_tlb_pkg::SIZE_LSB], 6'h00};
    end
  end

  for (genvar i = 0; i < 64; i++) begin : g_thit
    assign thit[i] = tcam_q[i][cache_tlb_pkg::VALID_BIT] &
                     (tcam_q[i][31:20] == modified_virtual_address[31:20]) &
                     (((tcam_q[i][19:10] ^ modified_virtual_address[19:10]) &
                       size_mask(tcam_q[i][9:6])) == 10'h000);
  end

  always_comb begin
    thit_idx = 6'h00;
    for (int i = 63; i >= 0; i--) begin
      if (thit[i]) begin
        thit_idx = 6'(i);
      end
    end
  end

  // A match miss has no walker behind it; only the miss bit is reported
  logic [31:0] mmu_test_data_reg_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mmu_test_data_reg_q <= cache_tlb_pkg::RST_WORD;
    end else if (t_camrd) begin
      mmu_test_data_reg_q <= tcam_q[tvp_q];
    end else if (t_r1rd) begin
      mmu_test_data_reg_q <= tr1_q[tvp_q];
    end else if (t_r2rd) begin
      mmu_test_data_reg_q <= tr2_q[r2idx_q];
    end else if (t_match & |thit) begin
      mmu_test_data_reg_q <= {tr1_q[thit_idx][31:25], 3'h0, tr1_q[thit_idx][21:0]};
    end else if (t_match) begin
      mmu_test_data_reg_q <= 32'h0040_0000;
    end
  end

  // Translation base, domain access, fault status and fault address
  logic [31:0] translation_base_q, domain_access_q, fault_status_reg_q, fault_address_reg_q;
  logic sys_wr;
  assign sys_wr = wr & (op.op1 == cache_tlb_pkg::OP1_SYS) & (op.crm == 4'h0) & (op.op2 == 3'h0);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      translation_base_q <= cache_tlb_pkg::RST_WORD;
      domain_access_q <= cache_tlb_pkg::RST_WORD;
      fault_status_reg_q <= cache_tlb_pkg::RST_WORD;
      fault_address_reg_q <= cache_tlb_pkg::RST_WORD;
    end else if (sys_wr) begin
      case (op.crn)
        cache_tlb_pkg::CRN_BASE: translation_base_q <= wd;
        cache_tlb_pkg::CRN_DOMAIN: domain_access_q <= wd;
        cache_tlb_pkg::CRN_FSTAT: fault_status_reg_q <= wd;
        cache_tlb_pkg::CRN_FADDR: fault_address_reg_q <= wd;
        default: ;
      endcase
    end
  end

  // Interrupts: a new event wins over a clear in the same cycle
  logic [cache_tlb_pkg::EV_W-1:0] ev, irq_stat_q, irq_en_q;
  logic irq_space_wr;
  logic [16:0] badr;
  assign badr = {wb_req.adr, 2'b00};
  assign irq_space_wr = acc & wb_req.we & wb_req.adr[cache_tlb_pkg::IRQ_SPACE_BIT] & wb_req.sel[0];
  assign ev[cache_tlb_pkg::EV_TLB_MISS] = t_match & ~|thit;
  assign ev[cache_tlb_pkg::EV_TLB_INV] = inv_all | inv_one;
  assign ev[cache_tlb_pkg::EV_CACHE_MISS] = c_match & ~|chit;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= '0;
    end else if (irq_space_wr && badr == cache_tlb_pkg::IRQ_CLEAR_OFS) begin
      irq_stat_q <= (irq_stat_q & ~wd[cache_tlb_pkg::EV_W-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      irq_en_q <= '0;
    end else if (irq_space_wr && badr == cache_tlb_pkg::IRQ_ENABLE_OFS) begin
      irq_en_q <= wd[cache_tlb_pkg::EV_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // Read data; unmapped addresses and disabled test reads answer zero
  always_comb begin
    rdata_d = 32'h0;
    if (wb_req.adr[cache_tlb_pkg::IRQ_SPACE_BIT]) begin
      if (badr == cache_tlb_pkg::IRQ_STATUS_OFS) begin
        rdata_d = {29'h0, irq_stat_q};
      end else if (badr == cache_tlb_pkg::IRQ_ENABLE_OFS) begin
        rdata_d = {29'h0, irq_en_q};
      end
    end else if (is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_BASE, 4'h0, 3'h0)) begin
      rdata_d = translation_base_q;
    end else if (is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_DOMAIN, 4'h0, 3'h0)) begin
      rdata_d = domain_access_q;
    end else if (is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_FSTAT, 4'h0, 3'h0)) begin
      rdata_d = fault_status_reg_q;
    end else if (is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_FADDR, 4'h0, 3'h0)) begin
      rdata_d = fault_address_reg_q;
    end else if (is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_TLBLOCK, 4'h0, 3'h0)) begin
      rdata_d = {tbase_q, tvp_q, 19'h0, tpres_q};
    end else if (is_op(op, cache_tlb_pkg::OP1_SYS, cache_tlb_pkg::CRN_VICTIM, 4'h1, 3'h0)) begin
      rdata_d = {cvcap_q, 26'h0};
    end else if (is_op(op, cache_tlb_pkg::OP1_TSTATE, cache_tlb_pkg::CRN_TEST,
                       cache_tlb_pkg::CRM_TSTATE, cache_tlb_pkg::OP2_TSTATE)) begin
      rdata_d = {31'h0, test_en_q};
    end else if (test_en_q && is_op(op, cache_tlb_pkg::OP1_CDATA, cache_tlb_pkg::CRN_TEST,
                                    cache_tlb_pkg::CRM_DATA, 3'h0)) begin
      rdata_d = cache_test_data_reg_q;
    end else if (test_en_q && (op.op1 == cache_tlb_pkg::OP1_MMU) &&
                 (op.crn == cache_tlb_pkg::CRN_TEST) && (op.crm == cache_tlb_pkg::CRM_DATA) &&
                 (op.op2 == 3'h0 || op.op2 == cache_tlb_pkg::OP2_MREAD)) begin
      rdata_d = mmu_test_data_reg_q;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      dat_q <= cache_tlb_pkg::RST_WORD;
    end else begin
      ack_q <= acc;
      if (acc & ~wb_req.we) begin
        dat_q <= rdata_d;
      end
    end
  end

  assign wb_ack = ack_q;
  assign wb_dat_o = dat_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_vlb_load: assert property (vlb_wr |=> cvp_q[0] == cbase_q && cvp_q[3] == $past(cidx))
    else $error("victim and base not loaded together");
  a_vic_only: assert property (vic_wr |=> cvp_q[$past(seg)] == $past(cidx) && !auto_all_q)
    else $error("victim-only write wrong");
  a_cam_adv: assert property (c_camrd && cvp_sel != cache_tlb_pkg::IDX_MAX
    |=> cvp_q[$past(seg)] == $past(cvp_sel) + 6'h01)
    else $error("victim did not advance on CAM access");
  a_ram_hold: assert property ((c_ramrd | c_ramwr) && !auto_all_q |=> cvp_q[$past(seg)] == $past(cvp_sel))
    else $error("victim moved on RAM access in victim-only mode");
  a_cap_victim: assert property (c_camrd |=> cvcap_q == $past(cvp_sel))
    else $error("victim not captured on CAM read");
  a_cam_zero: assert property (c_camrd |=> cache_test_data_reg_q[6:5] == 2'b00)
    else $error("CAM read bits 6:5 not zero");
  a_tlb_miss: assert property (t_match && !(|thit) |=> mmu_test_data_reg_q == 32'h0040_0000
    && irq_stat_q[cache_tlb_pkg::EV_TLB_MISS])
    else $error("TLB miss not reported");
  a_ram2_delay: assert property ((t_camrd | t_camwr | t_r1rd | t_r1wr) |=> r2idx_q == $past(tvp_q))
    else $error("RAM2 index not delayed copy");
  a_test_gate: assert property (!test_en_q && wr |=> $stable(cache_test_data_reg_q)
    && $stable(mmu_test_data_reg_q))
    else $error("test operation acted while disabled");
  a_ack_pulse: assert property (acc |=> wb_ack ##1 !wb_ack)
    else $error("ack not a single pulse");

  c_cam_loop: cover property (c_camwr ##[1:20] c_camrd);
  c_tlb_hit: cover property (t_match && |thit);
  c_irq_rise: cover property (!irq ##1 irq);

endmodule : cache_tlb_test_access

//--- core_model.sv
// Processor-side model issuing coprocessor transfers over classic Wishbone
`timescale 1ns/10ps
module core_model (
  input wire logic mclk,
  output cache_tlb_pkg::wb_req_t wb_req,
  input wire logic wb_ack,
  input wire logic [31:0] wb_dat_o
);
  int n_late = 0;
  initial wb_req = '0;
  // Request held until ack is sampled; the idle cycle before it keeps cycles apart
  task automatic xfer(input logic w, input logic [14:0] a, input logic [31:0] d,
    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    wb_req <= '{1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (wb_ack !== 1'b1) begin
      n_late++;
    end
    q = wb_dat_o;
    wb_req <= '0;
  endtask : xfer
endmodule : core_model

//--- cache_tlb_test_access_test.sv
// Self-checking bench for the cache and TLB test-access block
`timescale 1ns/10ps
module cache_tlb_test_access_test;
  localparam logic [14:0] IEN = cache_tlb_pkg::IRQ_ENABLE_OFS[16:2];
  localparam logic [14:0] ICLR = cache_tlb_pkg::IRQ_CLEAR_OFS[16:2];
  localparam logic [14:0] ISTAT = cache_tlb_pkg::IRQ_STATUS_OFS[16:2];
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic wb_ack, irq;
  logic [31:0] wb_dat_o, q;
  logic [3:0] rn [4] = '{4'h2, 4'h3, 4'h5, 4'h6};
  cache_tlb_pkg::wb_req_t wb_req;
  int err_total = 0;
  int num_checks = 0;
  always #2.5 mclk = ~mclk;
  cache_tlb_test_access dut_u (.mclk(mclk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .irq(irq));
  core_model core_u (.mclk(mclk), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o));
  function automatic logic [14:0] cp(input logic [2:0] o1, input logic [3:0] n, m,
    input logic [2:0] o2);
    return {1'b0, o1, n, m, o2};
  endfunction : cp
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input logic [31:0] d);
    core_u.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [14:0] a, input logic [31:0] e);
    core_u.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic print_verdict;
    err_total += core_u.n_late;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    wr(cp(3'h7, 4'hF, 4'hF, 3'h7), 32'h1);
    rd(cp(3'h7, 4'hF, 4'hF, 3'h7), 32'h1);
    rd(cp(3'h5, 4'h1, 4'h0, 3'h0), 32'h0);
    foreach (rn[i]) wr(cp(3'h0, rn[i], 4'h0, 3'h0), {28'hC3A5F00, rn[i]});
    foreach (rn[i]) rd(cp(3'h0, rn[i], 4'h0, 3'h0), {28'hC3A5F00, rn[i]});
    $display("system registers done");
    wr(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h17FFFFDF);
    wr(cp(3'h2, 4'hF, 4'hB, 3'h6), 32'h40);
    wr(cp(3'h2, 4'hF, 4'h7, 3'h2), 32'h40);
    rd(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h14000000);
    wr(cp(3'h2, 4'hF, 4'h7, 3'h2), 32'h40);
    rd(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h18000000);
    wr(cp(3'h0, 4'h9, 4'h0, 3'h0), 32'h0FFFFFFF);
    wr(cp(3'h2, 4'hF, 4'hB, 3'h2), 32'h20);
    wr(cp(3'h2, 4'hF, 4'h7, 3'h2), 32'h20);
    rd(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h10000000);
    $display("victim modes done");
    wr(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h24000060);
    wr(cp(3'h2, 4'hF, 4'h7, 3'h6), 32'hFFFFFFFE);
    wr(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h24000060);
    wr(cp(3'h2, 4'hF, 4'h7, 3'h2), 32'h60);
    rd(cp(3'h3, 4'hF, 4'h3, 3'h0), 32'hFFFFFF9E);
    $display("cache tag done");
    wr(cp(3'h0, 4'hA, 4'h0, 3'h0), 32'h08500001);
    rd(cp(3'h0, 4'hA, 4'h0, 3'h0), 32'h08500001);
    wr(cp(3'h0, 4'hA, 4'h0, 3'h0), 32'h0);
    wr(cp(3'h4, 4'hF, 4'h7, 3'h0), 32'h5A5A5A5F);
    wr(cp(3'h4, 4'hF, 4'h7, 3'h4), 32'h0);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'h5A5A5A50);
    $display("tlb cam done");
    wr(IEN, 32'h1);
    wr(cp(3'h4, 4'hF, 4'hD, 3'h4), 32'h0);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'h00400000);
    chk({31'h0, irq}, 32'h1);
    rd(ISTAT, 32'h1);
    wr(IEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ICLR, 32'h1);
    wr(IEN, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rd(ISTAT, 32'h0);
    $display("tlb miss interrupt done");
    wr(cp(3'h0, 4'hA, 4'h0, 3'h0), 32'h0);
    wr(cp(3'h4, 4'hF, 4'hB, 3'h0), 32'h0025A5A8);
    wr(cp(3'h4, 4'hF, 4'hB, 3'h4), 32'h0);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'h0025A5A3);
    wr(cp(3'h4, 4'hF, 4'h3, 3'h1), 32'hF0F0F0FF);
    wr(cp(3'h0, 4'hA, 4'h0, 3'h0), 32'h0);
    wr(cp(3'h4, 4'hF, 4'hB, 3'h4), 32'h0);
    wr(cp(3'h4, 4'hF, 4'h3, 3'h5), 32'h0);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'hF0F0F0C0);
    wr(cp(3'h0, 4'hA, 4'h0, 3'h0), 32'h0);
    wr(cp(3'h4, 4'hF, 4'h7, 3'h0), 32'h12345DE0);
    wr(cp(3'h4, 4'hF, 4'hD, 3'h4), 32'h12340000);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'h0025A5A3);
    wr(cp(3'h4, 4'hF, 4'hD, 3'h4), 32'h12380000);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'h00400000);
    wr(cp(3'h0, 4'h8, 4'h7, 3'h0), 32'h0);
    wr(cp(3'h4, 4'hF, 4'hD, 3'h4), 32'h12340000);
    rd(cp(3'h4, 4'hF, 4'h3, 3'h0), 32'h00400000);
    $display("tlb ram and match done");
    wr(cp(3'h3, 4'hF, 4'h3, 3'h0), 32'hA5A5A5A5);
    wr(cp(3'h0, 4'h9, 4'h1, 3'h0), 32'h24000060);
    wr(cp(3'h2, 4'hF, 4'hB, 3'h6), 32'h68);
    wr(cp(3'h2, 4'hF, 4'h7, 3'h5), 32'hFFFFFFE8);
    rd(cp(3'h3, 4'hF, 4'h3, 3'h0), 32'hA5A5A5A5);
    wr(cp(3'h7, 4'hF, 4'hF, 3'h7), 32'h0);
    wr(cp(3'h3, 4'hF, 4'h3, 3'h0), 32'h1);
    rd(cp(3'h3, 4'hF, 4'h3, 3'h0), 32'h0);
    rd(cp(3'h7, 4'hF, 4'hF, 3'h7), 32'h0);
    $display("cache match and test gate done");
    print_verdict();
  end
endmodule : cache_tlb_test_access_test
